// >>> mcg_clock_gen.sv
// Control and status logic of the multipurpose clock generator.
// Assumes a classic Wishbone master and an analog clock core steered by these outputs.
//
// Notes on behaviour
// - Source select 10 routes the external reference to the system clock.
// - Reference divider 111 divides by 128, 010 by 4.
// - Internal reference select cleared makes the external clock the reference.
// - Reference status reads 0 once the external reference is really in use.
// - Clock status shows 10 for external, 11 for PLL driving the output.
// - Low-power set in external bypass enters bypassed low power; cleared goes to PLL bypassed once the PLL mux has switched, else external bypass.
// - Low power keeps both loops off; field writes only preset later use.
// - Loop select set chooses the phase-locked loop over the FLL.
// - Multiplier 0100 multiplies the PLL reference by 16.
// - Loop status sets once the PLL really feeds the loop clock.
// - Lock status sets when the PLL has acquired lock.
// - Source select 00 with PLL selected routes loop output to system clock.
// - With a loop engaged, output is reference over divider times multiplier over bus divider; bus half.
`default_nettype none

module mcg_clock_gen #(
  parameter int SWITCH_CYC = mcg_pkg::MCG_SWITCH_CYC,
  parameter int LOCK_CYC = mcg_pkg::MCG_LOCK_CYC,
  parameter int FLL_FACTOR = mcg_pkg::MCG_FLL_FACTOR
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Clock core steering
  output logic [1:0] sys_clk_sel_out,
  output logic ext_ref_sel_out,
  output logic fll_enable_out,
  output logic pll_enable_out,
  output logic [7:0] ref_div_ratio_out,
  output logic [9:0] gen_mult_out,
  output logic [9:0] gen_div_out,
  output logic [10:0] bus_div_out,
  output logic [2:0] mode_out
);
  localparam int LCW = $clog2(LOCK_CYC + 1);

  generate
    if (LOCK_CYC < 1 || SWITCH_CYC < 1 || FLL_FACTOR < 1 || FLL_FACTOR > 1023) begin : g_bad
      $error("mcg_clock_gen parameter out of range");
    end
  endgenerate

  // ==========================================================
  // Helpers
  // Ratio of a power-of-two divider code
  function automatic logic [7:0] pow2(input logic [2:0] code);
    pow2 = 8'h01 << code;
  endfunction : pow2

  // Total divisor of the generator output: reference ratio times bus ratio
  // Limitation: 128 with bus code 3 needs 1024, which the 10-bit port cannot show
  function automatic logic [9:0] out_div(input logic [2:0] rcode, input logic [1:0] bcode);
    out_div = 10'({2'h0, pow2(rcode)} << bcode);
  endfunction : out_div

  // Bus clock divisor, one more halving; 3-bit shift count so bus code 3 cannot wrap
  function automatic logic [10:0] bus_ratio(input logic [2:0] rcode,
                                            input logic [1:0] bcode);
    bus_ratio = 11'({3'h0, pow2(rcode)} << (3'(bcode) + 3'h1));
  endfunction : bus_ratio

  // ==========================================================
  // Registers and state
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_three_q;
  logic lock_q;
  logic [LCW-1:0] lock_cnt_q;
  // Register fields, decoded once
  logic [1:0] src_sel;
  logic [2:0] ref_div;
  logic int_ref;
  logic [1:0] bus_div;
  logic low_power;
  logic loop_sel;
  logic [3:0] loop_mult;
  // Loop enables and switch handshakes
  logic lp_eff;
  logic pll_on;
  logic fll_on;
  logic loop_req;
  logic loop_done;
  logic ref_done;
  logic [1:0] clk_req;
  logic [1:0] clk_done;
  // Bus side and mode decode
  logic [7:0] status;
  logic [7:0] rd_data;
  logic wr_fire;
  logic [7:0] cfg_prev_q;
  mcg_pkg::mcg_mode_t mode_d;
  // Next values of the ratio outputs
  logic [9:0] gen_mult_d;
  logic [9:0] gen_div_d;
  logic [10:0] bus_div_d;

  assign src_sel = ctrl_one_q[mcg_pkg::MCG_SRC_SEL_HI:mcg_pkg::MCG_SRC_SEL_LO];
  assign ref_div = ctrl_one_q[mcg_pkg::MCG_REFERENCE_DIVIDER_HI:mcg_pkg::MCG_REFERENCE_DIVIDER_LO];
  assign int_ref = ctrl_one_q[mcg_pkg::MCG_IREF_BIT];
  assign bus_div = ctrl_two_q[mcg_pkg::MCG_BUS_DIVIDER_HI:mcg_pkg::MCG_BUS_DIVIDER_LO];
  assign low_power = ctrl_two_q[mcg_pkg::MCG_LP_BIT];
  assign loop_sel = ctrl_three_q[mcg_pkg::MCG_LOOP_SEL_BIT];
  assign loop_mult = ctrl_three_q[mcg_pkg::MCG_MULT_HI:mcg_pkg::MCG_MULT_LO];

  // ==========================================================
  // Loop enables
  // Low power only counts while bypassing; engaging a loop overrides it
  assign lp_eff = low_power && (src_sel != mcg_pkg::MCG_SRC_LOOP);
  assign pll_on = !lp_eff && loop_sel;
  assign fll_on = !lp_eff && !loop_sel;

  // ==========================================================
  // Wishbone slave: ack one cycle after the request, write at ack edge
  // One wait state, so a master first sees ack at its second edge
  assign wr_fire = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
    end
  end

  // Control registers, only the low byte lane is implemented
  // Lanes other than sel[0] are ignored, upper read bytes are zero
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl_one_q <= mcg_pkg::MCG_RST_CTRL_ONE;
      ctrl_two_q <= mcg_pkg::MCG_RST_CTRL_TWO;
      ctrl_three_q <= mcg_pkg::MCG_RST_CTRL_THREE;
    end else if (wr_fire) begin
      unique case (wb_adr_in)
        mcg_pkg::MCG_OFS_CTRL_ONE: ctrl_one_q <= wb_dat_in[7:0];
        mcg_pkg::MCG_OFS_CTRL_TWO: ctrl_two_q <= wb_dat_in[7:0];
        mcg_pkg::MCG_OFS_CTRL_THREE: ctrl_three_q <= wb_dat_in[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer with zero, status is read-only
  always_comb begin
    unique case (wb_adr_in)
      mcg_pkg::MCG_OFS_CTRL_ONE: rd_data = ctrl_one_q;
      mcg_pkg::MCG_OFS_CTRL_TWO: rd_data = ctrl_two_q;
      mcg_pkg::MCG_OFS_CTRL_THREE: rd_data = ctrl_three_q;
      mcg_pkg::MCG_OFS_STATUS: rd_data = status;
      default: rd_data = 8'h00;
    endcase
  end

  // Read data caught on the request edge, so it already stands when ack is sampled
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in) begin
      wb_dat_out <= {24'h00_0000, rd_data};
    end
  end

  // ==========================================================
  // Switch trackers
  // Reference mux: cleared select means external reference
  mcg_switch #(
    .WIDTH(1),
    .DELAY(SWITCH_CYC),
    .INIT(1'b1)
  ) u_ref_switch (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .req_in(int_ref),
    .done_out(ref_done)
  );

  // Loop clock mux follows the loop select only while the loops run
  assign loop_req = pll_on;

  mcg_switch #(
    .WIDTH(1),
    .DELAY(SWITCH_CYC),
    .INIT(1'b0)
  ) u_loop_switch (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .req_in(loop_req),
    .done_out(loop_done)
  );

  // Output mux request; the loop leg waits for the loop mux itself
  always_comb begin
    unique case (src_sel)
      mcg_pkg::MCG_SRC_LOOP: clk_req = loop_done ? mcg_pkg::MCG_ST_PLL
                                                  : mcg_pkg::MCG_ST_FLL;
      mcg_pkg::MCG_SRC_INTERNAL: clk_req = mcg_pkg::MCG_ST_INTERNAL;
      mcg_pkg::MCG_SRC_EXTERNAL: clk_req = mcg_pkg::MCG_ST_EXTERNAL;
      default: clk_req = mcg_pkg::MCG_ST_EXTERNAL; // Reserved code treated as bypass
    endcase
  end

  mcg_switch #(
    .WIDTH(2),
    .DELAY(SWITCH_CYC),
    .INIT(mcg_pkg::MCG_ST_FLL)
  ) u_clk_switch (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .req_in(clk_req),
    .done_out(clk_done)
  );

  // ==========================================================
  // Lock detection
  // Any change to the PLL's divider or multiplier drops lock and restarts the count
  // A settle count stands in for the analog lock detector
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cfg_prev_q <= 8'h00;
    end else begin
      cfg_prev_q <= {1'b0, ref_div, loop_mult};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (!pll_on || !loop_done || cfg_prev_q != {1'b0, ref_div, loop_mult}) begin
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else if (lock_cnt_q != LCW'(LOCK_CYC)) begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end else begin
      lock_q <= 1'b1;
    end
  end

  // ==========================================================
  // Status byte, built only from completed switches and the lock flag
  // A poll therefore never sees a request before its switch is over
  always_comb begin
    status = 8'h00;
    status[mcg_pkg::MCG_LOCK_BIT] = lock_q;
    status[mcg_pkg::MCG_LOOP_ST_BIT] = loop_done;
    status[mcg_pkg::MCG_REF_ST_BIT] = ref_done;
    status[mcg_pkg::MCG_CLK_ST_HI:mcg_pkg::MCG_CLK_ST_LO] = clk_done;
  end

  // ==========================================================
  // Mode decode, from what is really in effect
  always_comb begin
    unique case (clk_done)
      mcg_pkg::MCG_ST_EXTERNAL: begin
        if (lp_eff) begin
          mode_d = mcg_pkg::MCG_MODE_LOW_POWER;
        end else if (loop_done) begin
          mode_d = mcg_pkg::MCG_MODE_PLL_BYPASS;
        end else begin
          mode_d = mcg_pkg::MCG_MODE_EXT_BYPASS;
        end
      end
      mcg_pkg::MCG_ST_PLL: mode_d = mcg_pkg::MCG_MODE_PLL_ENGAGED;
      mcg_pkg::MCG_ST_FLL: mode_d = mcg_pkg::MCG_MODE_FLL_ENGAGED;
      mcg_pkg::MCG_ST_INTERNAL: mode_d = mcg_pkg::MCG_MODE_INTERNAL;
    endcase
  end

  // ==========================================================
  // Steering outputs, all registered
  // Registered so the analog core never sees a decode glitch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sys_clk_sel_out <= mcg_pkg::MCG_ST_FLL;
      ext_ref_sel_out <= 1'b0;
      fll_enable_out <= 1'b0;
      pll_enable_out <= 1'b0;
      mode_out <= 3'h0;
    end else begin
      sys_clk_sel_out <= clk_req;
      ext_ref_sel_out <= !int_ref;
      fll_enable_out <= fll_on;
      pll_enable_out <= pll_on;
      mode_out <= 3'(mode_d);
    end
  end

  // Frequency ratios; the PLL factor is four per multiplier step
  // They follow the completed switch, so they never run ahead of the status
  always_comb begin
    unique case (clk_done)
      mcg_pkg::MCG_ST_PLL: begin
        gen_mult_d = 10'(int'(loop_mult) * mcg_pkg::MCG_LOOP_MULT_STEP);
        gen_div_d = out_div(ref_div, bus_div);
        bus_div_d = bus_ratio(ref_div, bus_div);
      end
      mcg_pkg::MCG_ST_FLL: begin
        gen_mult_d = 10'(FLL_FACTOR);
        gen_div_d = out_div(ref_div, bus_div);
        bus_div_d = bus_ratio(ref_div, bus_div);
      end
      mcg_pkg::MCG_ST_EXTERNAL, mcg_pkg::MCG_ST_INTERNAL: begin
        gen_mult_d = 10'h001; // Bypass: reference over bus divider
        gen_div_d = out_div(3'h0, bus_div);
        bus_div_d = bus_ratio(3'h0, bus_div);
      end
    endcase
  end

  // Ratio outputs, registered like the steering
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ref_div_ratio_out <= 8'h01;
      gen_mult_out <= 10'h001;
      gen_div_out <= 10'h001;
      bus_div_out <= 11'h002;
    end else begin
      ref_div_ratio_out <= pow2(ref_div);
      gen_mult_out <= gen_mult_d;
      gen_div_out <= gen_div_d;
      bus_div_out <= bus_div_d;
    end
  end
endmodule : mcg_clock_gen

`default_nettype wire

// >>> mcg_clock_gen_checker.sv
// Port checks for the clock generator control block.
// Assumes one clock domain with a synchronous active high reset.
`default_nettype none

module mcg_clock_gen_checker (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic [1:0] sys_clk_sel_out,
  input wire logic ext_ref_sel_out,
  input wire logic fll_enable_out,
  input wire logic pll_enable_out,
  input wire logic [9:0] gen_div_out,
  input wire logic [10:0] bus_div_out,
  input wire logic [2:0] mode_out
);
  logic wr_one;
  // ==========================================================
  // Completed write to control one; steering lags it by a cycle
  assign wr_one = wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == 4'h0;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  property p_ack_rise;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack late");
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_src_ext;
    wr_one && wb_dat_in[7:6] == 2'h2 |-> ##2 sys_clk_sel_out == 2'h2;
  endproperty
  a_src_ext: assert property (p_src_ext) else $error("source select wrong");
  property p_ext_ref;
    wr_one |-> ##2 ext_ref_sel_out == !$past(wb_dat_in[2], 2);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("reference select wrong");
  property p_lp_off;
    mode_out == mcg_pkg::MCG_MODE_LOW_POWER |-> !fll_enable_out && !pll_enable_out;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("loop on in low power");
  property p_bus_half;
    bus_div_out == {gen_div_out, 1'b0};
  endproperty
  a_bus_half: assert property (p_bus_half) else $error("bus divider not double");
  property p_pee_pll;
    mode_out == mcg_pkg::MCG_MODE_PLL_ENGAGED [*2] |-> pll_enable_out;
  endproperty
  a_pee_pll: assert property (p_pee_pll) else $error("loop off when engaged");
  property p_fbe_ext;
    mode_out == mcg_pkg::MCG_MODE_EXT_BYPASS [*2] |-> ext_ref_sel_out;
  endproperty
  a_fbe_ext: assert property (p_fbe_ext) else $error("bypass without reference");
  // Main scenarios reached
  c_wr_one: cover property (wr_one);
  c_lp: cover property (mode_out == mcg_pkg::MCG_MODE_LOW_POWER);
  c_pee: cover property (mode_out == mcg_pkg::MCG_MODE_PLL_ENGAGED);
endmodule : mcg_clock_gen_checker

bind mcg_clock_gen mcg_clock_gen_checker mcg_clock_gen_checker_inst (.mclk_in, .srst_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out,
  .sys_clk_sel_out, .ext_ref_sel_out, .fll_enable_out, .pll_enable_out, .gen_div_out,
  .bus_div_out, .mode_out);

`default_nettype wire

// >>> mcg_dummy_unused.sv
`default_nettype none
`default_nettype wire

// >>> mcg_pkg.sv
// Constants shared by the clock generator control block.
// Assumes a 32-bit classic Wishbone slave; registers sit in the low byte of each word.
`default_nettype none

package mcg_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] MCG_OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] MCG_OFS_CTRL_TWO = 4'h4;
  localparam logic [3:0] MCG_OFS_CTRL_THREE = 4'h8;
  localparam logic [3:0] MCG_OFS_STATUS = 4'hc;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MCG_RST_CTRL_ONE = 8'h04;
  localparam logic [7:0] MCG_RST_CTRL_TWO = 8'h40;
  localparam logic [7:0] MCG_RST_CTRL_THREE = 8'h01;

  // ==========================================================
  // Field positions, control one
  localparam int MCG_SRC_SEL_HI = 7;
  localparam int MCG_SRC_SEL_LO = 6;
  localparam int MCG_REFERENCE_DIVIDER_HI = 5;
  localparam int MCG_REFERENCE_DIVIDER_LO = 3;
  localparam int MCG_IREF_BIT = 2;
  // Control two
  localparam int MCG_BUS_DIVIDER_HI = 7;
  localparam int MCG_BUS_DIVIDER_LO = 6;
  localparam int MCG_LP_BIT = 3;
  // Control three
  localparam int MCG_LOOP_SEL_BIT = 6;
  localparam int MCG_MULT_HI = 3;
  localparam int MCG_MULT_LO = 0;
  // Status
  localparam int MCG_LOCK_BIT = 6;
  localparam int MCG_LOOP_ST_BIT = 5;
  localparam int MCG_REF_ST_BIT = 4;
  localparam int MCG_CLK_ST_HI = 3;
  localparam int MCG_CLK_ST_LO = 2;

  // ==========================================================
  // Source select and clock status codes
  localparam logic [1:0] MCG_SRC_LOOP = 2'h0;
  localparam logic [1:0] MCG_SRC_INTERNAL = 2'h1;
  localparam logic [1:0] MCG_SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] MCG_ST_FLL = 2'h0;
  localparam logic [1:0] MCG_ST_INTERNAL = 2'h1;
  localparam logic [1:0] MCG_ST_EXTERNAL = 2'h2;
  localparam logic [1:0] MCG_ST_PLL = 2'h3;

  // ==========================================================
  // Timing, clock 100 MHz
  localparam int MCG_CLK_MHZ = 100;
  localparam int MCG_SWITCH_NS = 80;
  localparam int MCG_SWITCH_CYC = (MCG_SWITCH_NS * MCG_CLK_MHZ + 999) / 1000;
  localparam int MCG_LOCK_US = 10;
  localparam int MCG_LOCK_CYC = MCG_LOCK_US * MCG_CLK_MHZ;
  localparam int MCG_LOOP_MULT_STEP = 4;
  localparam int MCG_FLL_FACTOR = 512;

  // Operating mode as seen by the hardware
  typedef enum logic [2:0] {
    MCG_MODE_INTERNAL,
    MCG_MODE_EXT_BYPASS,
    MCG_MODE_LOW_POWER,
    MCG_MODE_PLL_BYPASS,
    MCG_MODE_FLL_ENGAGED,
    MCG_MODE_PLL_ENGAGED
  } mcg_mode_t;
endpackage : mcg_pkg

`default_nettype wire

// >>> mcg_ref_osc.sv
// Behavioural external reference oscillator for the clock generator bench.
// Assumes its enable follows the generator's external reference select.
`default_nettype none

module mcg_ref_osc #(
  parameter int HALF_NS = 125
) (
  input wire logic enable_in,
  output logic ref_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Oscillator, 4 MHz so divide by 128 and by 4 land in range
  // Parked low while unselected, so no stray edges between uses
  initial ref_clk_out = 1'b0;
  always begin
    #(HALF_NS);
    ref_clk_out = enable_in ? ~ref_clk_out : 1'b0;
  end
endmodule : mcg_ref_osc

`default_nettype wire

// >>> mcg_switch.sv
// Glitch-free switch tracker: reports a request as done only after it held steady.
// Assumes the mux it shadows needs a fixed number of cycles to change over.
`default_nettype none

module mcg_switch #(
  parameter int WIDTH = 2,
  parameter int DELAY = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] req_in,
  output logic [WIDTH-1:0] done_out
);
  localparam int CW = $clog2(DELAY + 1);

  logic [CW-1:0] cnt_q;
  logic [WIDTH-1:0] pend_q;

  generate
    if (DELAY < 1) begin : g_bad
      $error("mcg_switch DELAY must be at least one");
    end
  endgenerate

  // ==========================================================
  // Restart the wait whenever the request moves mid-switch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pend_q <= INIT;
      cnt_q <= '0;
      done_out <= INIT;
    end else if (req_in != pend_q) begin
      pend_q <= req_in;
      cnt_q <= CW'(DELAY);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == CW'(1)) begin
        done_out <= pend_q; // Status moves only after the change-over
      end
    end
  end
endmodule : mcg_switch

`default_nettype wire

// >>> tb.sv
// Self-checking bench walking the generator from FLL engaged to PLL engaged.
// Assumes the design, checker and oscillator model are compiled before it.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, ext_sel, fll_en, pll_en, ref_clk;
  logic [1:0] clk_sel;
  logic [7:0] reference_divider, q, c2;
  logic [9:0] mult, gdiv;
  logic [10:0] bus_divider;
  logic [2:0] mode;
  realtime per;
  logic [7:0] rst [4] = '{8'h04, 8'h40, 8'h01, 8'h10};
  int num_errors = 0, n_compared = 0, seed = 32'h4289;
  // ==========================================================
  // Clock and instances; short lock count keeps the run brief
  always #5 mclk_in = ~mclk_in;
  mcg_clock_gen #(.LOCK_CYC(20)) mcg_clock_gen_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .sys_clk_sel_out(clk_sel),
    .ext_ref_sel_out(ext_sel), .fll_enable_out(fll_en), .pll_enable_out(pll_en),
    .ref_div_ratio_out(reference_divider), .gen_mult_out(mult), .gen_div_out(gdiv),
    .bus_div_out(bus_divider), .mode_out(mode));
  mcg_ref_osc mcg_ref_osc_inst (.enable_in(ext_sel), .ref_clk_out(ref_clk));
  // ==========================================================
  // Helpers
  function automatic logic [9:0] exp_div(input logic [2:0] r, input logic [1:0] b);
    return (10'h1 << r) * (10'h1 << b);
  endfunction : exp_div
  // Divided reference period against a period span, all in ns
  function automatic logic in_span(input realtime p, input int d, input real lo, input real hi);
    return (p * d >= lo) && (p * d <= hi);
  endfunction : in_span
  task automatic ref_period(output realtime p);
    realtime t0;
    @(posedge ref_clk);
    t0 = $realtime;
    @(posedge ref_clk);
    p = $realtime - t0;
  endtask : ref_period
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One classic cycle held until ack; only the watchdog ends a dead slave's wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [7:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk_in);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'hc, 4'h1, 8'h0);
      n++;
    end while ((q & m) !== v && n < 100);
    check("status", q & m, v);
  endtask : poll
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Watchdog, far beyond the few hundred cycles the walk needs
  initial begin
    #200000;
    num_errors++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4), 4'h1, 8'h0);
      check("reset", q, rst[i]);
    end
    bus(1'b0, 4'h2, 4'h1, 8'h0);
    check("unmapped", q, 8'h00);
    bus(1'b1, 4'hc, 4'h1, 8'hff);
    poll(8'hff, 8'h10);
    bus(1'b1, 4'h8, 4'he, 8'hff);
    bus(1'b0, 4'h8, 4'h1, 8'h0);
    check("lane_off", q, 8'h01);
    $display("test registers done");
    repeat (6) begin
      c2 = 8'($random(seed));
      bus(1'b1, 4'h4, 4'h1, c2);
      bus(1'b0, 4'h4, 4'h1, 8'h0);
      check("ctrl_two", q & 8'hc8, c2 & 8'hc8);
    end
    // Low power cleared so the next write lands in plain bypass
    c2 = c2 & 8'hc0;
    bus(1'b1, 4'h4, 4'h1, c2);
    $display("test random done");
    bus(1'b1, 4'h0, 4'h1, 8'hb8);
    poll(8'h1c, 8'h08);
    repeat (3) @(posedge mclk_in);
    check("mode", mode, mcg_pkg::MCG_MODE_EXT_BYPASS);
    check("ref_div", reference_divider, 8'd128);
    check("gen_div", gdiv, exp_div(3'h0, c2[7:6]));
    check("clk_sel", clk_sel, 2'h2);
    check("ext_sel", ext_sel, 1'b1);
    ref_period(per);
    check("fll_ref", in_span(per, 128, 25600.0, 32000.0), 1'b1);
    $display("test bypass done");
    bus(1'b1, 4'h4, 4'h1, 8'h08);
    repeat (3) @(posedge mclk_in);
    check("mode", mode, mcg_pkg::MCG_MODE_LOW_POWER);
    bus(1'b1, 4'h0, 4'h1, 8'h90);
    bus(1'b1, 4'h8, 4'h1, 8'h44);
    repeat (30) @(posedge mclk_in);
    check("loops", {fll_en, pll_en}, 2'b00);
    poll(8'h60, 8'h00);
    bus(1'b1, 4'h4, 4'h1, 8'h00);
    // Bypass with the PLL running shows only once the loop mux has switched
    poll(8'h20, 8'h20);
    repeat (3) @(posedge mclk_in);
    check("mode", mode, mcg_pkg::MCG_MODE_PLL_BYPASS);
    poll(8'h40, 8'h40);
    check("pll_en", pll_en, 1'b1);
    $display("test low power done");
    bus(1'b1, 4'h0, 4'h1, 8'h10);
    poll(8'h0c, 8'h0c);
    repeat (3) @(posedge mclk_in);
    check("mode", mode, mcg_pkg::MCG_MODE_PLL_ENGAGED);
    check("mult", mult, 10'd16);
    check("ref_div", reference_divider, 8'd4);
    check("gen_div", gdiv, exp_div(3'h2, 2'h0));
    check("bus_div", bus_divider, {exp_div(3'h2, 2'h0), 1'b0});
    check("clk_sel", clk_sel, 2'h3);
    ref_period(per);
    check("pll_ref", in_span(per, 4, 500.0, 1000.0), 1'b1);
    bus(1'b1, 4'h8, 4'h1, 8'h45);
    bus(1'b0, 4'hc, 4'h1, 8'h0);
    check("lock_drop", q[6], 1'b0);
    poll(8'h40, 8'h40);
    $display("test engaged done");
    results();
  end
endmodule : tb

`default_nettype wire
